/* shared/fsr_pkg.sv */
// Constants for the flash security and status register bank.
// Assumes a 32-bit APB slave with each register in one aligned word.
package fsr_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [9:0]  IDX_SEC     = 10'h001;
    localparam logic [9:0]  IDX_CMDIX   = 10'h002;
    localparam logic [9:0]  IDX_PSTAT   = 10'h003;
    localparam logic [9:0]  IDX_CFG     = 10'h004;
    localparam logic [9:0]  IDX_IRQST   = 10'h008;
    localparam logic [9:0]  IDX_IRQMSK  = 10'h009;
    // Security byte location and values.
    localparam logic [23:0] SEC_BYTE_ADDR  = 24'hff_fe0f;
    localparam logic [7:0]  SEC_RESET      = 8'hff;
    localparam logic [7:0]  SEC_FAULT      = 8'hff;
    localparam int          KEY_MSB        = 7;
    localparam int          KEY_LSB        = 6;
    localparam int          LOCK_MSB       = 1;
    localparam int          LOCK_LSB       = 0;
    localparam logic [1:0]  KEY_ON         = 2'h2;
    localparam logic [1:0]  LOCK_OPEN      = 2'h2;
    localparam logic [1:0]  LOCK_PREFERRED = 2'h1;
    // Command word index field.
    localparam int          IX_W           = 3;
    localparam logic [2:0]  IX_RESET       = 3'h0;
    // Wait-state select field and switch timing.
    localparam int          WS_W           = 2;
    localparam int          WS_LSB         = 2;
    localparam logic [1:0]  WS_RESET       = 2'h3;
    localparam int          WS_SWITCH_CYCLES = 4;
    // Protection status bit positions.
    localparam int          PST_OVR_BIT    = 7;
    localparam int          PST_ACK_BIT    = 0;
    // Interrupt event bits.
    localparam int          EV_W           = 4;
    localparam int          EV_LOAD        = 0;
    localparam int          EV_FAULT       = 1;
    localparam int          EV_WSACK       = 2;
    localparam int          EV_UNLOCK      = 3;
    localparam logic [3:0]  EV_RESET       = 4'h0;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } fsr_load_t;
endpackage

/* shared/fsr_ws_if.sv */
// Wait-state switch request and status between the register bank
// and its switch sequencer; both sit on one clock.
`timescale 1ns/1ps
`default_nettype none
interface fsr_ws_if;
    import fsr_pkg::*;
    logic            req;
    logic [WS_W-1:0] sel;
    logic [WS_W-1:0] eff;
    logic            ack;
    modport ctrl (output req, output sel, input eff, input ack);
    modport seq  (input req, input sel, output eff, output ack);
endinterface
`default_nettype wire

/* verification/test_flash_security_status_regs.sv */
// Self-checking bench for the flash security and status register bank.
// Assumes the bench drives every port itself, APB included.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_flash_security_status_regs;
    import fsr_pkg::*;
    localparam int SC = 3;
    typedef struct {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wd;
        logic        prot;
        logic [31:0] exp;
        logic        err;
    } fsr_row_t;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, NVM_REQ, KEY_ACCESS_EN, FLASH_SECURED, IRQ;
    logic [23:0] NVM_ADDR;
    logic        NVM_ACK = 1'b0, NVM_DBL_FAULT = 1'b0, BACKDOOR_UNLOCK = 1'b0;
    logic [7:0]  NVM_DATA = 8'h00;
    logic        PROT_OVERRIDE = 1'b0, CMD_COMPLETE = 1'b1;
    logic [1:0]  READ_WAIT_STATES;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          total_checks = 0;
    fsr_row_t    rows [12];

    fsr_top #(.SWITCH_CYCLES(SC)) fsr_top_i (
        .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .NVM_REQ(NVM_REQ),
        .NVM_ADDR(NVM_ADDR), .NVM_ACK(NVM_ACK), .NVM_DATA(NVM_DATA),
        .NVM_DBL_FAULT(NVM_DBL_FAULT), .BACKDOOR_UNLOCK(BACKDOOR_UNLOCK),
        .KEY_ACCESS_EN(KEY_ACCESS_EN), .FLASH_SECURED(FLASH_SECURED),
        .PROT_OVERRIDE(PROT_OVERRIDE), .CMD_COMPLETE(CMD_COMPLETE),
        .READ_WAIT_STATES(READ_WAIT_STATES), .IRQ(IRQ)
    );

    always #5 CLOCK = ~CLOCK;

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; holds the request until PREADY is seen high.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge CLOCK);
            if (PREADY === 1'b1)
                break;
        end
        if (n == 20)
        begin
            err_total++;
            test_done();
        end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rd, er);
        `CHK(rd, x)
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    // Security byte load answer; data line shows inverse once released.
    task automatic nvm_load(input logic [7:0] d, input logic f);
        @(posedge CLOCK);
        NVM_ACK <= 1'b1;
        NVM_DATA <= d;
        NVM_DBL_FAULT <= f;
        @(posedge CLOCK);
        NVM_ACK <= 1'b0;
        NVM_DATA <= ~d;
        NVM_DBL_FAULT <= 1'b0;
        @(posedge CLOCK);
        #1;
        `CHK(NVM_REQ, 1'b0)
    endtask

    task automatic backdoor();
        @(posedge CLOCK);
        BACKDOOR_UNLOCK <= 1'b1;
        @(posedge CLOCK);
        BACKDOOR_UNLOCK <= 1'b0;
        @(posedge CLOCK);
    endtask

    initial
    begin
        rows = '{
            '{1'b1, 12'h004, 32'h0000_0000, 1'b0, 32'h0, 1'b0},
            '{1'b0, 12'h004, 32'h0, 1'b0, 32'h0000_00bc, 1'b0},
            '{1'b1, 12'h008, 32'hffff_ffff, 1'b0, 32'h0, 1'b0},
            '{1'b0, 12'h008, 32'h0, 1'b0, 32'h0000_0007, 1'b0},
            '{1'b1, 12'h008, 32'h0000_0002, 1'b0, 32'h0, 1'b0},
            '{1'b0, 12'h008, 32'h0, 1'b0, 32'h0000_0002, 1'b0},
            '{1'b1, 12'h00c, 32'hffff_ffff, 1'b1, 32'h0, 1'b0},
            '{1'b0, 12'h00c, 32'h0, 1'b1, 32'h0000_0081, 1'b0},
            '{1'b0, 12'h00c, 32'h0, 1'b0, 32'h0000_0001, 1'b0},
            '{1'b0, 12'h040, 32'h0, 1'b0, 32'h0000_0000, 1'b1},
            '{1'b1, 12'h040, 32'h0000_00ff, 1'b0, 32'h0, 1'b1},
            '{1'b1, 12'h024, 32'h0000_000f, 1'b0, 32'h0, 1'b0}};
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        #1;
        `CHK(NVM_REQ, 1'b1)
        `CHK(NVM_ADDR, SEC_BYTE_ADDR)
        `CHK(READ_WAIT_STATES, WS_RESET)
        `CHK(FLASH_SECURED, 1'b1)
        rd_chk({IDX_SEC, 2'b00}, {24'h0, SEC_RESET});
        nvm_load(8'hbc, 1'b0);
        `CHK(KEY_ACCESS_EN, 1'b1)
        `CHK(FLASH_SECURED, 1'b1)
        $display("test reset_load done");

        foreach (rows[i])
        begin
            PROT_OVERRIDE <= rows[i].prot;
            apb(rows[i].wr, rows[i].addr, rows[i].wd, rd, er);
            `CHK(er, rows[i].err)
            if (!rows[i].wr)
                `CHK(rd, rows[i].exp)
        end
        $display("test table done");

        CMD_COMPLETE <= 1'b0;
        wr({IDX_CFG, 2'b00}, 32'h0000_0004);
        CMD_COMPLETE <= 1'b1;
        rd_chk({IDX_CFG, 2'b00}, 32'h0000_000c);
        `CHK(READ_WAIT_STATES, WS_RESET)
        wr({IDX_CFG, 2'b00}, 32'h0000_0004);
        for (int k = 1; k <= SC + 1; k++)
        begin
            @(posedge CLOCK);
            #1;
            `CHK(READ_WAIT_STATES, (k >= SC) ? 2'h1 : 2'h3)
        end
        rd_chk({IDX_PSTAT, 2'b00}, 32'h0000_0001);
        wr({IDX_CFG, 2'b00}, 32'h0000_0000);
        #1;
        `CHK(READ_WAIT_STATES, 2'h1)
        rd_chk({IDX_PSTAT, 2'b00}, 32'h0000_0000);
        for (int n = 0; READ_WAIT_STATES !== 2'h0; n++)
        begin
            if (n == 20)
            begin
                err_total++;
                test_done();
            end
            @(posedge CLOCK);
            #1;
        end
        `CHK(READ_WAIT_STATES, 2'h0)
        rd_chk({IDX_PSTAT, 2'b00}, 32'h0000_0001);
        $display("test wait_switch done");

        rd_chk({IDX_IRQST, 2'b00}, 32'h0000_0005);
        `CHK(IRQ, 1'b1)
        wr({IDX_IRQST, 2'b00}, 32'h0000_0001);
        rd_chk({IDX_IRQST, 2'b00}, 32'h0000_0004);
        wr({IDX_IRQMSK, 2'b00}, 32'h0000_0000);
        #1;
        `CHK(IRQ, 1'b0)
        wr({IDX_IRQST, 2'b00}, 32'h0000_0004);
        backdoor();
        rd_chk({IDX_SEC, 2'b00}, 32'h0000_00be);
        `CHK(FLASH_SECURED, 1'b0)
        rd_chk({IDX_IRQST, 2'b00}, 32'h0000_0008);
        `CHK(IRQ, 1'b0)
        wr({IDX_IRQMSK, 2'b00}, 32'h0000_0008);
        #1;
        `CHK(IRQ, 1'b1)
        wr({IDX_IRQST, 2'b00}, 32'h0000_0008);
        @(posedge CLOCK);
        `CHK(IRQ, 1'b0)
        $display("test irq_backdoor done");

        // Second reset in mid-run, then a faulty security byte load.
        @(posedge CLOCK);
        RST <= 1'b1;
        repeat (3) @(posedge CLOCK);
        RST <= 1'b0;
        rd_chk({IDX_CMDIX, 2'b00}, {29'h0, IX_RESET});
        rd_chk({IDX_CFG, 2'b00}, {28'h0, WS_RESET, 2'b00});
        nvm_load(8'hbe, 1'b1);
        rd_chk({IDX_SEC, 2'b00}, {24'h0, SEC_FAULT});
        backdoor();
        rd_chk({IDX_SEC, 2'b00}, {24'h0, SEC_FAULT});
        `CHK(KEY_ACCESS_EN, 1'b0)
        `CHK(FLASH_SECURED, 1'b1)
        $display("test fault_load done");
        test_done();
    end
endmodule // test_flash_security_status_regs
`default_nettype wire

/* verilog/fsr_top.sv */
// Flash security and status register bank behind an APB slave.
// Assumes the NVM, backdoor, protection and command-complete inputs
// come from flash controller logic on the same clock.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fsr_top
    import fsr_pkg::*;
#(
    parameter int SWITCH_CYCLES = WS_SWITCH_CYCLES
)(
    // Clock and reset.
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Security byte load from non-volatile storage.
    output logic             NVM_REQ,
    output logic      [23:0] NVM_ADDR,
    input  wire logic        NVM_ACK,
    input  wire logic [7:0]  NVM_DATA,
    input  wire logic        NVM_DBL_FAULT,
    // Security state.
    input  wire logic        BACKDOOR_UNLOCK,
    output logic             KEY_ACCESS_EN,
    output logic             FLASH_SECURED,
    // Flash controller status.
    input  wire logic        PROT_OVERRIDE,
    input  wire logic        CMD_COMPLETE,
    output logic [fsr_pkg::WS_W-1:0] READ_WAIT_STATES,
    // Interrupt.
    output logic             IRQ
);
    import fsr_pkg::*;

    fsr_ws_if ws ();

    fsr_load_t        state;
    logic [7:0]       sec;
    logic [IX_W-1:0]  cmd_index;
    logic [WS_W-1:0]  ws_sel;
    logic [EV_W-1:0]  irq_status;
    logic [EV_W-1:0]  irq_mask;
    logic             ack_q;
    logic [31:0]      next_rdata;
    logic             next_hit;

    logic [9:0]       word;
    logic             setup;
    logic             wr;
    logic             load_done;
    logic             unlock;
    logic [EV_W-1:0]  events;
    logic [WS_W-1:0]  ws_new;

    fsr_wait_switch #(
        .SWITCH_CYCLES (SWITCH_CYCLES)
    ) u_switch (
        .clk (CLOCK),
        .rst (RST),
        .ws  (ws)
    );

    // Bus decode; the slave never inserts wait states.
    assign word   = PADDR[11:2];
    assign setup  = PSEL & ~PENABLE;
    assign wr     = PSEL & PENABLE & PWRITE;
    assign PREADY = 1'b1;

    always_comb
    begin
        next_hit = 1'b1;
        case (word)
            IDX_SEC, IDX_CMDIX, IDX_PSTAT, IDX_CFG,
            IDX_IRQST, IDX_IRQMSK: next_hit = 1'b1;
            default:               next_hit = 1'b0;
        endcase
    end

    // Unmapped addresses answer with an error and read as zero.
    assign PSLVERR = PSEL & PENABLE & ~next_hit;

    // Security byte load after reset, then backdoor unlock handling.
    assign NVM_REQ   = (state == ST_LOAD);
    assign NVM_ADDR  = SEC_BYTE_ADDR;
    assign load_done = NVM_REQ & NVM_ACK;
    assign unlock    = (state == ST_RUN) & BACKDOOR_UNLOCK
                     & (sec[KEY_MSB:KEY_LSB] == KEY_ON);

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            state <= ST_LOAD;
            sec   <= SEC_RESET;
        end
        else
        begin
            case (state)
                ST_LOAD:
                begin
                    if (NVM_ACK)
                    begin
                        state <= ST_RUN;
                        if (NVM_DBL_FAULT)
                            sec <= SEC_FAULT;
                        else
                            sec <= NVM_DATA;
                    end
                end
                ST_RUN:
                begin
                    if (unlock)
                        sec[LOCK_MSB:LOCK_LSB] <= LOCK_OPEN;
                end
                default:
                begin
                    state <= ST_LOAD;
                end
            endcase
        end
    end

    // Bus writes never reach the unlock byte.
    assign KEY_ACCESS_EN = (sec[KEY_MSB:KEY_LSB] == KEY_ON);
    assign FLASH_SECURED = (sec[LOCK_MSB:LOCK_LSB] != LOCK_OPEN);

    // Command word index register.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            cmd_index <= IX_RESET;
        else if (wr && word == IDX_CMDIX)
            cmd_index <= PWDATA[IX_W-1:0];
    end

    // Wait-state select; a change during a running command is dropped.
    assign ws_new = PWDATA[WS_LSB +: WS_W];
    assign ws.req = wr & (word == IDX_CFG) & CMD_COMPLETE
                  & (ws_new != ws_sel);
    assign ws.sel = ws_new;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            ws_sel <= WS_RESET;
        else if (ws.req)
            ws_sel <= ws_new;
    end

    assign READ_WAIT_STATES = ws.eff;

    // Sticky interrupt status, cleared by writing ones; set wins.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            ack_q <= 1'b1;
        else
            ack_q <= ws.ack;
    end

    always_comb
    begin
        events            = EV_RESET;
        events[EV_LOAD]   = load_done;
        events[EV_FAULT]  = load_done & NVM_DBL_FAULT;
        events[EV_WSACK]  = ws.ack & ~ack_q;
        events[EV_UNLOCK] = unlock;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            irq_status <= EV_RESET;
        else if (wr && word == IDX_IRQST)
            irq_status <= (irq_status & ~PWDATA[EV_W-1:0]) | events;
        else
            irq_status <= irq_status | events;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            irq_mask <= EV_RESET;
        else if (wr && word == IDX_IRQMSK)
            irq_mask <= PWDATA[EV_W-1:0];
    end

    assign IRQ = |(irq_status & irq_mask);

    // Read data is chosen in the setup cycle and held for the access.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (word)
            IDX_SEC:
                next_rdata[7:0] = sec;
            IDX_CMDIX:
                next_rdata[IX_W-1:0] = cmd_index;
            IDX_PSTAT:
            begin
                next_rdata[PST_OVR_BIT] = PROT_OVERRIDE;
                next_rdata[PST_ACK_BIT] = ws.ack;
            end
            IDX_CFG:
                next_rdata[WS_LSB +: WS_W] = ws_sel;
            IDX_IRQST:
                next_rdata[EV_W-1:0] = irq_status;
            IDX_IRQMSK:
                next_rdata[EV_W-1:0] = irq_mask;
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            PRDATA <= 32'h0000_0000;
        else if (setup && !PWRITE)
            PRDATA <= next_rdata;
    end

    property p_load;
        @(posedge CLOCK) disable iff (RST)
            load_done && !NVM_DBL_FAULT |=> sec == $past(NVM_DATA);
    endproperty
    a_load: assert property (p_load)
        else $error("Unlock byte did not take the loaded value.");

    property p_fault;
        @(posedge CLOCK) disable iff (RST)
            load_done && NVM_DBL_FAULT |=> sec == SEC_FAULT
            ##1 !NVM_REQ;
    endproperty
    a_fault: assert property (p_fault)
        else $error("Double fault did not set every unlock bit.");

    property p_sec_ro;
        @(posedge CLOCK) disable iff (RST)
            wr && word == IDX_SEC && !load_done && !unlock
            |=> $stable(sec);
    endproperty
    a_sec_ro: assert property (p_sec_ro)
        else $error("A bus write changed the unlock byte.");

    property p_backdoor;
        @(posedge CLOCK) disable iff (RST)
            unlock |=> sec[LOCK_MSB:LOCK_LSB] == LOCK_OPEN && !FLASH_SECURED;
    endproperty
    a_backdoor: assert property (p_backdoor)
        else $error("Backdoor unlock did not open the lock field.");

    property p_key_gate;
        @(posedge CLOCK) disable iff (RST)
            state == ST_RUN && BACKDOOR_UNLOCK
            && sec[KEY_MSB:KEY_LSB] != KEY_ON |=> $stable(sec);
    endproperty
    a_key_gate: assert property (p_key_gate)
        else $error("Backdoor acted with key access disabled.");

    property p_index_wr;
        @(posedge CLOCK) disable iff (RST)
            wr && word == IDX_CMDIX |=> cmd_index == $past(PWDATA[2:0]);
    endproperty
    a_index_wr: assert property (p_index_wr)
        else $error("Command index did not take the written value.");

    property p_index_zero;
        @(posedge CLOCK) disable iff (RST)
            setup && !PWRITE && word == IDX_CMDIX
            |=> PRDATA[31:3] == 29'h0;
    endproperty
    a_index_zero: assert property (p_index_zero)
        else $error("Upper command index bits did not read zero.");

    property p_override;
        @(posedge CLOCK) disable iff (RST)
            setup && !PWRITE && word == IDX_PSTAT
            |=> PRDATA[7] == $past(PROT_OVERRIDE) && PRDATA[6:1] == 6'h00;
    endproperty
    a_override: assert property (p_override)
        else $error("Override status read back wrong.");

    property p_busy_ws;
        @(posedge CLOCK) disable iff (RST)
            wr && word == IDX_CFG && !CMD_COMPLETE
            |=> $stable(ws_sel) && !$fell(ws.ack);
    endproperty
    a_busy_ws: assert property (p_busy_ws)
        else $error("Wait select changed during a running command.");

    c_load: cover property (@(posedge CLOCK) disable iff (RST)
        load_done && !NVM_DBL_FAULT);
    c_fault: cover property (@(posedge CLOCK) disable iff (RST)
        load_done && NVM_DBL_FAULT);
    c_unlock: cover property (@(posedge CLOCK) disable iff (RST) unlock);
    c_switch: cover property (@(posedge CLOCK) disable iff (RST)
        ws.req ##[1:20] events[EV_WSACK]);
endmodule // fsr_top
`default_nettype wire

/* verilog/fsr_wait_switch.sv */
// Wait-state switch sequencer: holds the wait setting used by flash
// reads and moves it to a newly requested value after a settle delay.
// Assumes one-cycle requests from the register bank on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fsr_wait_switch
    import fsr_pkg::*;
#(
    parameter int SWITCH_CYCLES = WS_SWITCH_CYCLES
)(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Switch request and status.
    fsr_ws_if.seq     ws
);
    logic            pending;
    logic [WS_W-1:0] target;
    logic [7:0]      count;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pending <= 1'b0;
            target  <= WS_RESET;
            count   <= 8'h00;
            ws.eff  <= WS_RESET;
            ws.ack  <= 1'b1;
        end
        else if (ws.req)
        begin
            pending <= 1'b1;
            target  <= ws.sel;
            count   <= 8'(SWITCH_CYCLES - 1);
            ws.ack  <= 1'b0;
        end
        else if (pending)
        begin
            if (count == 8'h00)
            begin
                pending <= 1'b0;
                ws.eff  <= target;
                ws.ack  <= 1'b1;
            end
            else
            begin
                count <= count - 8'h01;
            end
        end
    end

    property p_ack_clear;
        @(posedge clk) disable iff (rst) ws.req |=> !ws.ack;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("Acknowledge did not clear on a switch request.");

    property p_ack_set;
        @(posedge clk) disable iff (rst)
            ws.req ##1 (!ws.req)[*4] |=> ws.ack;
    endproperty
    a_ack_set: assert property (p_ack_set)
        else $error("Acknowledge did not set after the switch delay.");

    property p_old_setting;
        @(posedge clk) disable iff (rst) !ws.ack |=> $stable(ws.eff)
            or $rose(ws.ack);
    endproperty
    a_old_setting: assert property (p_old_setting)
        else $error("Read wait setting changed before the switch ended.");
endmodule // fsr_wait_switch
`default_nettype wire
